// >>> verilog/ssf_pkg.sv
// Constants and carrier types for the SPI serial unit.
// Assumes one core clock drives both the register port and the serial engine.
//
// Notes on behaviour
// - Overflow flag stays set until software writes one to it.
// - Overflow flag clears whenever the receiver is off.
// - Instant notify: overflow flag rises at the overflow itself.
// - Deferred notify: marker follows the data, read returns zero and sets flag.
// - Slave with address format checks the first character against the address.
// - Match sets receive complete, enables MISO, transaction proceeds.
// - Address match can wake the system from sleep.
// - Mismatch: whole transaction ignored, nothing stored, MISO idle.
// - Nine-bit characters compare only the low eight bits.
// - Without preload the slave first shifts out the current shift register.
// - Preload moves one character while select is high; next waits.
// - Preload works only when its enable bit is one.
// - Same input and output pad gives loop-back through the pad.
// - Three flags: register empty, receive complete, transmit complete; all wake except in a slave with rsb set, where only receive complete does.
// - One to enable-set enables a source, one to enable-clear disables it.
// - Shared request high while any flag and its enable are set.
// - Master: clock runs in sleep if asked, else stops after transaction.
// - Slave: in sleep only receive complete or address match wakes, or all reception drops.
// - Reset, enable and receiver-enable writes pass a synchroniser first.
// - Received character enters the buffer and flags in its last-bit cycle.
// - Slave stays idle with MISO off while select is high.
package ssf_pkg;
	// =====================================================
	// Register offsets
	localparam logic [7:0] OFS_PRIMARY = 8'h00;
	localparam logic [7:0] OFS_SECONDARY = 8'h04;
	localparam logic [7:0] OFS_DBG = 8'h08;
	localparam logic [7:0] OFS_BAUD = 8'h0a;
	localparam logic [7:0] OFS_IEN_CLR = 8'h0c;
	localparam logic [7:0] OFS_IEN_SET = 8'h0d;
	localparam logic [7:0] OFS_FLAGS = 8'h0e;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_ADDR = 8'h14;
	localparam logic [7:0] OFS_DATA = 8'h18;
	// =====================================================
	// Field positions
	localparam int B_SOFT_RESET_BIT = 0;
	localparam int B_ENABLE = 1;
	localparam int B_MODE = 2;
	localparam int B_RSB = 7;
	localparam int B_INSTANT_OVERFLOW_NOTIFY = 8;
	localparam int B_OUTPUT_PAD_SELECT = 16;
	localparam int B_INPUT_PAD_SELECT = 20;
	localparam int B_FRAME_FORMAT = 24;
	localparam int B_CPHA = 28;
	localparam int B_CPOL = 29;
	localparam int B_DORD = 30;
	localparam int B_CHARACTER_WIDTH = 0;
	localparam int B_PLOAD = 6;
	localparam int B_HW_SELECT_ENABLE = 13;
	localparam int B_RECEIVER_ENABLE_BIT = 17;
	localparam int B_MASK = 16;
	localparam int B_DRE = 0;
	localparam int B_TXC = 1;
	localparam int B_RXC = 2;
	localparam int B_OVF = 2;
	localparam int B_BUSY = 15;
	// =====================================================
	// Encodings and reset values
	localparam logic [2:0] MODE_SLAVE = 3'h2;
	localparam logic [2:0] MODE_MASTER = 3'h3;
	localparam logic [3:0] FRAME_FORMAT_ADDR = 4'h2;
	localparam logic [2:0] CHARACTER_WIDTH_9 = 3'h1;
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [8:0] RST_SHIFT = 9'h000;
	// Pad used for data out, clock and slave select, indexed by output pad select
	localparam logic [7:0] OUTPUT_PAD_SELECT_DO = {2'h0, 2'h3, 2'h2, 2'h0};
	localparam logic [7:0] OUTPUT_PAD_SELECT_SCK = {2'h3, 2'h1, 2'h3, 2'h1};
	localparam logic [7:0] OUTPUT_PAD_SELECT_SS = {2'h1, 2'h2, 2'h1, 2'h2};
	// =====================================================
	// Carrier types
	typedef struct packed {
		logic [3:0] o;
		logic [3:0] oe;
	} ssf_pad_t;
	typedef struct packed {
		logic mark;
		logic [8:0] data;
	} ssf_rx_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_ACT = 2'b11,
		ST_SKIP = 2'b10
	} ssf_state_t;
endpackage

// >>> verilog/ssf_spi.sv
// SPI serial unit: register port, master/slave shift engine, receive buffer.
// Assumes pad inputs are asynchronous and the register port runs on core_clk_i.
`timescale 1ns/1ns
module ssf_spi (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [31:0] rdata_o,
	// Pads
	input wire logic [3:0] pad_i,
	output ssf_pkg::ssf_pad_t pad_o,
	output logic ss_n_o,
	// System
	input wire logic standby_i,
	output logic irq_o,
	output logic wake_o,
	output logic core_clk_req_o
);
	import ssf_pkg::*;

	// =====================================================
	// Registers
	logic [31:0] primary_control, secondary_control, addr_reg;
	logic [7:0] dbg_reg, baud_reg;
	logic [2:0] inten;
	logic transmit_complete_flag, ovf, mark;
	logic en_s1, en_q, rx_s1, rx_q, sw_req, sw_s1, sw_q;
	logic [8:0] txh;
	logic txv;
	ssf_rx_t fifo [2];
	logic wp, rp;
	logic [1:0] cnt;
	logic [31:0] rdata;

	wire srst = sw_q;
	wire wr_a = we_i && addr_i == OFS_PRIMARY;
	wire wr_b = we_i && addr_i == OFS_SECONDARY;
	wire wr_clr = we_i && addr_i == OFS_IEN_CLR;
	wire wr_set = we_i && addr_i == OFS_IEN_SET;
	wire wr_flag = we_i && addr_i == OFS_FLAGS;
	wire wr_stat = we_i && addr_i == OFS_STATUS;
	wire wr_data = we_i && addr_i == OFS_DATA;
	wire rd_data = re_i && addr_i == OFS_DATA;

	wire [2:0] mode = primary_control[B_MODE+:3];
	wire master = mode == MODE_MASTER;
	wire slave = mode == MODE_SLAVE;
	wire rsb = primary_control[B_RSB];
	wire instant_overflow_notify = primary_control[B_INSTANT_OVERFLOW_NOTIFY];
	wire [1:0] output_pad_select = primary_control[B_OUTPUT_PAD_SELECT+:2];
	wire [1:0] input_pad_select = primary_control[B_INPUT_PAD_SELECT+:2];
	wire addr_mode = primary_control[B_FRAME_FORMAT+:4] == FRAME_FORMAT_ADDR;
	wire cpha = primary_control[B_CPHA];
	wire cpol = primary_control[B_CPOL];
	wire lsb = primary_control[B_DORD];
	wire nine = secondary_control[B_CHARACTER_WIDTH+:3] == CHARACTER_WIDTH_9;
	wire pload = secondary_control[B_PLOAD];
	wire hw_select_enable = secondary_control[B_HW_SELECT_ENABLE];
	wire busy_sync = (en_q != primary_control[B_ENABLE]) || (rx_q != secondary_control[B_RECEIVER_ENABLE_BIT]) || sw_req;

	// =====================================================
	// Pad synchronisers and selection
	logic [3:0] pad_m, pad_s;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge core_clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					pad_m[gi] <= 1'b1;
					pad_s[gi] <= 1'b1;
				end else begin
					pad_m[gi] <= pad_i[gi];
					pad_s[gi] <= pad_m[gi];
				end
			end
		end
	endgenerate

	wire [1:0] do_pad = OUTPUT_PAD_SELECT_DO[2*output_pad_select+:2];
	wire [1:0] sck_pad = OUTPUT_PAD_SELECT_SCK[2*output_pad_select+:2];
	wire [1:0] ss_pad = OUTPUT_PAD_SELECT_SS[2*output_pad_select+:2];
	// Reading the data-in pad sees our own drive when it equals the out pad
	wire din = pad_s[input_pad_select];
	wire ss_hi = pad_s[ss_pad];

	// =====================================================
	// Shift engine signals
	ssf_state_t state;
	logic [8:0] sh;
	logic [3:0] bcnt;
	logic rbit, fresh, preloaded, msck, mbusy, mstop, sck_prev, ss_prev;
	logic [7:0] div;

	function automatic logic [8:0] shin(input logic [8:0] s, input logic d,
			input logic n9, input logic lf);
		if (!lf)
			shin = n9 ? {s[7:0], d} : {1'b0, s[6:0], d};
		else
			shin = n9 ? {d, s[8:1]} : {1'b0, d, s[7:1]};
	endfunction

	wire drop = standby_i && slave && !rsb;
	wire sck_cur = master ? msck : pad_s[sck_pad];
	wire rise = sck_cur && !sck_prev;
	wire fall = !sck_cur && sck_prev;
	wire samp_e = (cpol == cpha) ? rise : fall;
	wire chg_e = (cpol == cpha) ? fall : rise;
	wire s_on = en_q && slave && !ss_hi && !drop && state != ST_IDLE;
	wire run = s_on || (master && mbusy);
	wire samp = run && samp_e;
	wire chg = run && chg_e;
	wire last = bcnt == (nine ? 4'h8 : 4'h7);
	wire done = samp && last;
	wire [8:0] rxw = shin(sh, din, nine, lsb);
	wire match = ((rxw[7:0] ^ addr_reg[7:0]) & ~addr_reg[B_MASK+:8]) == 8'h00;
	wire first_chk = done && state == ST_ADDR;
	wire hit = first_chk && match;
	wire store = done && rx_q && (master || state == ST_ACT || hit);
	wire out_bit = lsb ? sh[0] : (nine ? sh[8] : sh[7]);
	wire do_en = en_q && (master || (slave && s_on && state == ST_ACT));
	wire ss_rise = ss_hi && !ss_prev;
	wire m_start = en_q && master && !mbusy && txv;
	wire tick = mbusy && div == baud_reg;
	wire preload = en_q && slave && ss_hi && pload && !preloaded && txv;
	wire load_b = done && txv && state != ST_SKIP;
	wire tx_take = m_start || load_b || preload;

	// =====================================================
	// Receive buffer
	wire full = cnt == 2'h2;
	wire ovf_evt = store && (full || mark);
	wire push = store && !full && !mark;
	wire pop = rd_data && cnt != 2'h0;
	wire mark_rd = rd_data && cnt == 2'h0 && mark;
	wire receive_complete_flag = cnt != 2'h0 || mark;
	wire [2:0] flags = {receive_complete_flag, transmit_complete_flag, !txv};
	wire txc_set = (slave && ss_rise && state != ST_IDLE && state != ST_SKIP)
		|| (master && mbusy && mstop && tick && !msck == cpol)
		|| (master && done && !txv && cpha);

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'h0;
			mark <= 1'b0;
			fifo[0] <= '0;
			fifo[1] <= '0;
		end else if (srst || !rx_q) begin
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'h0;
			mark <= 1'b0;
		end else begin
			if (push) begin
				fifo[wp] <= '{mark: 1'b0, data: rxw};
				wp <= !wp;
			end
			if (pop)
				rp <= !rp;
			cnt <= cnt + {1'b0, push} - {1'b0, pop};
			if (ovf_evt && !instant_overflow_notify)
				mark <= 1'b1;
			else if (mark_rd)
				mark <= 1'b0;
		end
	end

	// =====================================================
	// Control registers and write synchronisers
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			primary_control <= RST_CTRL;
			secondary_control <= RST_CTRL;
			addr_reg <= RST_CTRL;
			dbg_reg <= 8'h00;
			baud_reg <= 8'h00;
			inten <= 3'h0;
			sw_req <= 1'b0;
		end else begin
			if (wr_a)
				primary_control <= {wdata_i[31:1], 1'b0};
			if (wr_b)
				secondary_control <= wdata_i;
			if (we_i && addr_i == OFS_ADDR)
				addr_reg <= wdata_i;
			if (we_i && addr_i == OFS_DBG)
				dbg_reg <= wdata_i[7:0];
			if (we_i && addr_i == OFS_BAUD)
				baud_reg <= wdata_i[7:0];
			if (wr_set)
				inten <= inten | wdata_i[2:0];
			if (wr_clr)
				inten <= inten & ~wdata_i[2:0];
			if (wr_a && wdata_i[B_SOFT_RESET_BIT])
				sw_req <= 1'b1;
			if (srst) begin
				primary_control <= RST_CTRL;
				secondary_control <= RST_CTRL;
				addr_reg <= RST_CTRL;
				baud_reg <= 8'h00;
				inten <= 3'h0;
				sw_req <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{en_s1, en_q, rx_s1, rx_q, sw_s1, sw_q} <= 6'h00;
		end else begin
			en_s1 <= primary_control[B_ENABLE];
			en_q <= en_s1;
			rx_s1 <= secondary_control[B_RECEIVER_ENABLE_BIT];
			rx_q <= rx_s1;
			sw_s1 <= sw_req && !srst;
			sw_q <= sw_s1;
		end
	end

	// =====================================================
	// Flags and transmit holding word
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			transmit_complete_flag <= 1'b0;
			ovf <= 1'b0;
			txh <= 9'h000;
			txv <= 1'b0;
		end else if (srst) begin
			transmit_complete_flag <= 1'b0;
			ovf <= 1'b0;
			txv <= 1'b0;
		end else begin
			transmit_complete_flag <= txc_set || (transmit_complete_flag && !(wr_flag && wdata_i[B_TXC]));
			if (!rx_q)
				ovf <= 1'b0;
			else
				ovf <= (ovf_evt && instant_overflow_notify) || mark_rd || (ovf && !(wr_stat && wdata_i[B_OVF]));
			if (wr_data) begin
				txh <= wdata_i[8:0];
				txv <= 1'b1;
			end else if (tx_take)
				txv <= 1'b0;
		end
	end

	// =====================================================
	// Shift engine
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= ST_IDLE;
			sh <= RST_SHIFT;
			bcnt <= 4'h0;
			{rbit, fresh, preloaded, msck, mbusy, mstop, sck_prev, ss_prev} <= 8'h03;
			div <= 8'h00;
		end else if (srst) begin
			state <= ST_IDLE;
			sh <= RST_SHIFT;
			{mbusy, mstop, preloaded} <= 3'h0;
		end else begin
			sck_prev <= sck_cur;
			ss_prev <= ss_hi;
			if (preload) begin
				sh <= txh;
				preloaded <= 1'b1;
			end
			if (!slave || ss_hi || drop || !en_q) begin
				if (!master)
					state <= ST_IDLE;
				if (ss_rise)
					preloaded <= 1'b0;
			end else if (state == ST_IDLE) begin
				state <= addr_mode ? ST_ADDR : ST_ACT;
				bcnt <= 4'h0;
				fresh <= cpha;
			end
			if (m_start) begin
				sh <= txh;
				mbusy <= 1'b1;
				mstop <= 1'b0;
				bcnt <= 4'h0;
				fresh <= cpha;
				div <= 8'h00;
				msck <= cpol;
			end
			if (mbusy) begin
				div <= tick ? 8'h00 : div + 8'h01;
				if (tick) begin
					msck <= !msck;
					if (mstop && !msck == cpol)
						mbusy <= 1'b0;
				end
			end
			if (!mbusy)
				msck <= cpol;
			if (samp) begin
				rbit <= din;
				bcnt <= last ? 4'h0 : bcnt + 4'h1;
			end
			if (chg) begin
				if (fresh)
					fresh <= 1'b0;
				else
					sh <= shin(sh, rbit, nine, lsb);
			end
			if (done) begin
				fresh <= 1'b1;
				sh <= load_b ? txh : rxw;
				if (state == ST_ADDR)
					state <= match ? ST_ACT : ST_SKIP;
				if (master && !txv) begin
					mstop <= 1'b1;
					if (cpha)
						mbusy <= 1'b0;
				end
			end
		end
	end

	// =====================================================
	// Pads, read port and system outputs
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pad
			assign pad_o.o[gi] = (gi == do_pad) ? out_bit : msck;
			assign pad_o.oe[gi] = ((gi == do_pad) && do_en)
				|| ((gi == sck_pad) && (gi != do_pad) && en_q && master);
		end
	endgenerate

	wire [31:0] rd_mux =
		(addr_i == OFS_PRIMARY) ? primary_control :
		(addr_i == OFS_SECONDARY) ? secondary_control :
		(addr_i == OFS_DBG) ? {24'h0, dbg_reg} :
		(addr_i == OFS_BAUD) ? {24'h0, baud_reg} :
		(addr_i == OFS_IEN_CLR || addr_i == OFS_IEN_SET) ? {29'h0, inten} :
		(addr_i == OFS_FLAGS) ? {29'h0, flags} :
		(addr_i == OFS_STATUS) ? {16'h0, busy_sync, 12'h0, ovf, 2'h0} :
		(addr_i == OFS_ADDR) ? addr_reg :
		(addr_i == OFS_DATA && cnt != 2'h0) ? {23'h0, fifo[rp].data} :
		32'h0;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			rdata <= 32'h0;
		else
			rdata <= re_i ? rd_mux : 32'h0;
	end

	assign rdata_o = rdata;
	assign ss_n_o = !(master && hw_select_enable && mbusy);
	assign irq_o = |(flags & inten);
	assign wake_o = (slave && rsb) ? ((receive_complete_flag && inten[B_RXC]) || hit) : (irq_o || hit);
	assign core_clk_req_o = !(standby_i && master && !rsb && !mbusy);

	// =====================================================
	// Checks
	ovf_hold_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		ovf && rx_q && !srst && !(wr_stat && wdata_i[B_OVF]) |=> ovf)
		else $error("overflow flag dropped without clear");
	ovf_rxoff_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!rx_q |=> !ovf) else $error("overflow flag kept with receiver off");
	ovf_instant_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		ovf_evt && instant_overflow_notify && !srst && rx_q |=> ovf) else $error("instant overflow missed");
	marker_zero_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		mark_rd && rx_q && !srst |=> ovf && rdata_o == 32'h0)
		else $error("marker read not zero with flag");
	skip_quiet_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		state == ST_SKIP && slave |-> !do_en && !push) else $error("ignored frame active");
	ss_tristate_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		slave && ss_hi |-> !pad_o.oe[do_pad]) else $error("MISO driven while deselected");
	irq_clear_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		wr_clr && wdata_i[2:0] == 3'h7 && !wr_set |=> !irq_o) else $error("irq after disable");
	rx_push_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		push && !pop && !srst |=> cnt == $past(cnt) + 2'h1 && receive_complete_flag)
		else $error("character not buffered in its last-bit cycle");
endmodule

// >>> sim/ssf_master_model.sv
// External SPI master model: mode 0, MSB first, 8-bit characters.
// Assumes its lines reach the slave's pads unsynchronised; SCK idles low.
`timescale 1ns/1ns
module ssf_master_model (
	// Link lines
	output logic sck_o,
	output logic ss_n_o,
	output logic mosi_o,
	input wire logic miso_i
);
	// ==========================================
	// Frame control
	localparam time HALF = 400;
	initial begin
		sck_o = 1'b0;
		ss_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// Offset keeps link edges away from core clock edges
	task automatic open_frame();
		#37;
		ss_n_o = 1'b0;
		#HALF;
	endtask
	task automatic close_frame();
		#HALF;
		ss_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#HALF;
	endtask
	// ==========================================
	// One character; several may share one frame
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			#HALF;
			sck_o = 1'b1;
			rx[i] = miso_i;
			#HALF;
			sck_o = 1'b0;
		end
	endtask
endmodule

// >>> sim/ssf_spi_bench.sv
// Self-checking bench for the SPI unit in slave and master roles.
// Assumes the master model on pads 1-3 and MISO on pad 0 (output pad select 0).
`timescale 1ns/1ns
module ssf_spi_bench;
	import ssf_pkg::*;
	// ==========================================
	// Signals
	localparam int LIMIT = 30000;
	logic core_clk_i, arst_n_i, we_i, re_i, standby_i;
	logic [7:0] addr_i;
	logic [31:0] wdata_i, rdata_o, d;
	ssf_pad_t pad_o;
	logic ss_n_o, irq_o, wake_o, core_clk_req_o;
	logic sck, ss_n, mosi, miso;
	logic miso_last = 1'b0;
	logic [7:0] rxs [4];
	int num_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	// Released MISO toggles every cycle so no stale value passes
	assign miso = pad_o.oe[0] ? pad_o.o[0] : ~miso_last;
	always @(posedge core_clk_i) miso_last <= miso;
	ssf_spi i_ssf_spi (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
		.pad_i({mosi, ss_n, sck, miso}), .pad_o(pad_o), .ss_n_o(ss_n_o),
		.standby_i(standby_i), .irq_o(irq_o), .wake_o(wake_o),
		.core_clk_req_o(core_clk_req_o));
	ssf_master_model i_ssf_master_model (.sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi),
		.miso_i(miso));
	// ==========================================
	// Shared tasks
	task automatic end_sim();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		addr_i <= a;
		wdata_i <= v;
		we_i <= 1'b1;
		@(posedge core_clk_i);
		we_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge core_clk_i);
		re_i <= 1'b0;
		@(negedge core_clk_i);
		v = rdata_o;
		@(posedge core_clk_i);
	endtask
	task automatic rdbit(input logic [7:0] a, input int b, input logic exp, input string m);
		rd(a, d);
		chk(32'(d[b]), 32'(exp), m);
	endtask
	function automatic logic [31:0] pctl(input logic [3:0] frame_format, input logic instant_overflow_notify);
		pctl = (32'(MODE_SLAVE) << B_MODE) | (32'h1 << B_ENABLE) | (32'h3 << B_INPUT_PAD_SELECT)
			| (32'(frame_format) << B_FRAME_FORMAT) | (32'(instant_overflow_notify) << B_INSTANT_OVERFLOW_NOTIFY);
	endfunction
	// Characters first, first+0x11, ...; frame left open when close is 0
	task automatic burst(input logic [7:0] first, input int n, input logic close);
		i_ssf_master_model.open_frame();
		for (int i = 0; i < n; i++) begin
			i_ssf_master_model.xfer(first + 8'(i * 17), rxs[i]);
		end
		if (close)
			i_ssf_master_model.close_frame();
		tick(4);
	endtask
	task automatic shut();
		i_ssf_master_model.close_frame();
		tick(4);
	endtask
	task automatic drain();
		repeat (3) rd(OFS_DATA, d);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs();
		rd(OFS_PRIMARY, d);
		chk(d, RST_CTRL, "primary reset");
		rd(OFS_IEN_SET, d);
		chk(d, 32'h0, "enable reset");
		wr(OFS_BAUD, 32'h5a);
		rd(OFS_BAUD, d);
		chk(d & 32'hff, 32'h5a, "baud readback");
		wr(8'h1c, 32'hffff_ffff);
		rd(8'h1c, d);
		chk(d, 32'h0, "unmapped read");
	endtask
	task automatic t_no_preload();
		wr(OFS_SECONDARY, 32'h1 << B_RECEIVER_ENABLE_BIT);
		wr(OFS_PRIMARY, pctl(4'h0, 1'b0));
		tick(6);
		chk(32'(pad_o.oe[0]), 32'h0, "miso idle");
		burst(8'ha5, 1, 1'b0);
		rdbit(OFS_FLAGS, B_RXC, 1'b1, "rx flag at last bit");
		shut();
		chk(32'(rxs[0]), 32'(RST_SHIFT[7:0]), "reset shift out");
		burst(8'h5a, 1, 1'b1);
		chk(32'(rxs[0]), 32'ha5, "last char out");
		rd(OFS_DATA, d);
		chk(d & 32'hff, 32'ha5, "first char");
		rd(OFS_DATA, d);
		chk(d & 32'hff, 32'h5a, "second char");
	endtask
	task automatic t_preload();
		wr(OFS_SECONDARY, (32'h1 << B_RECEIVER_ENABLE_BIT) | (32'h1 << B_PLOAD));
		wr(OFS_DATA, 32'h3c);
		wr(OFS_DATA, 32'h69);
		tick(4);
		burst(8'h11, 2, 1'b1);
		chk(32'(rxs[0]), 32'h3c, "preloaded");
		chk(32'(rxs[1]), 32'h69, "held char");
		drain();
		wr(OFS_SECONDARY, 32'h1 << B_RECEIVER_ENABLE_BIT);
	endtask
	task automatic t_ovf_now();
		wr(OFS_PRIMARY, pctl(4'h0, 1'b1));
		burst(8'h11, 3, 1'b1);
		rdbit(OFS_STATUS, B_OVF, 1'b1, "overflow raised");
		tick(20);
		rdbit(OFS_STATUS, B_OVF, 1'b1, "overflow sticky");
		wr(OFS_STATUS, 32'h1 << B_OVF);
		rdbit(OFS_STATUS, B_OVF, 1'b0, "overflow cleared");
		rd(OFS_DATA, d);
		rd(OFS_DATA, d);
		rdbit(OFS_FLAGS, B_RXC, 1'b0, "drained");
		burst(8'h11, 3, 1'b1);
		wr(OFS_SECONDARY, 32'h0);
		tick(6);
		rdbit(OFS_STATUS, B_OVF, 1'b0, "rx off clears");
		wr(OFS_SECONDARY, 32'h1 << B_RECEIVER_ENABLE_BIT);
		tick(6);
		drain();
	endtask
	task automatic t_ovf_late();
		wr(OFS_PRIMARY, pctl(4'h0, 1'b0));
		burst(8'h11, 3, 1'b1);
		rd(OFS_DATA, d);
		chk(d & 32'hff, 32'h11, "late 1");
		rdbit(OFS_STATUS, B_OVF, 1'b0, "not yet");
		rd(OFS_DATA, d);
		chk(d & 32'hff, 32'h22, "late 2");
		rd(OFS_DATA, d);
		chk(d, 32'h0, "zero word");
		rdbit(OFS_STATUS, B_OVF, 1'b1, "late flag");
		wr(OFS_STATUS, 32'h1 << B_OVF);
	endtask
	task automatic t_addr();
		wr(OFS_SECONDARY, 32'h1 << B_RECEIVER_ENABLE_BIT);
		wr(OFS_ADDR, 32'h3c);
		wr(OFS_PRIMARY, pctl(FRAME_FORMAT_ADDR, 1'b0));
		tick(4);
		burst(8'h3c, 2, 1'b0);
		chk(32'(pad_o.oe[0]), 32'h1, "miso on match");
		rdbit(OFS_FLAGS, B_RXC, 1'b1, "match flag");
		shut();
		drain();
		burst(8'h3d, 2, 1'b0);
		chk(32'(pad_o.oe[0]), 32'h0, "miso off mismatch");
		shut();
		rdbit(OFS_FLAGS, B_RXC, 1'b0, "nothing stored");
		wr(OFS_ADDR, 32'h0001_003c);
		burst(8'h3d, 2, 1'b0);
		chk(32'(pad_o.oe[0]), 32'h1, "masked match");
		shut();
		drain();
	endtask
	task automatic t_irq();
		wr(OFS_PRIMARY, pctl(4'h0, 1'b0));
		wr(OFS_FLAGS, 32'h1 << B_TXC);
		wr(OFS_IEN_SET, 32'h1 << B_DRE);
		chk(32'(irq_o), 32'h1, "empty request");
		rd(OFS_IEN_CLR, d);
		chk(d, 32'h1 << B_DRE, "enable mask");
		wr(OFS_IEN_CLR, 32'h1 << B_DRE);
		chk(32'(irq_o), 32'h0, "disabled");
		wr(OFS_IEN_SET, 32'h1 << B_RXC);
		chk(32'(irq_o), 32'h0, "no flag");
		burst(8'h42, 1, 1'b1);
		chk(32'(irq_o), 32'h1, "rx request");
		rd(OFS_DATA, d);
		tick(1);
		chk(32'(irq_o), 32'h0, "rx read");
		wr(OFS_IEN_CLR, 32'h1 << B_RXC);
		wr(OFS_IEN_SET, 32'h1 << B_TXC);
		chk(32'(irq_o), 32'h1, "tx done request");
		wr(OFS_FLAGS, 32'h1 << B_TXC);
		chk(32'(irq_o), 32'h0, "tx cleared");
		wr(OFS_IEN_CLR, 32'h7);
	endtask
	task automatic t_standby();
		standby_i <= 1'b1;
		tick(2);
		burst(8'h77, 1, 1'b1);
		rdbit(OFS_FLAGS, B_RXC, 1'b0, "dropped in sleep");
		wr(OFS_PRIMARY, pctl(4'h0, 1'b0) | (32'h1 << B_RSB));
		wr(OFS_IEN_SET, 32'h1 << B_RXC);
		chk(32'(wake_o), 32'h0, "no wake while idle");
		burst(8'h78, 1, 1'b1);
		chk(32'(wake_o), 32'h1, "receive wakes in sleep");
		rd(OFS_DATA, d);
		chk(d & 32'hff, 32'h78, "kept in sleep");
		wr(OFS_IEN_CLR, 32'h7);
		standby_i <= 1'b0;
		tick(2);
	endtask
	// Master on pad 0 with data in on the same pad: loop-back
	task automatic t_master();
		wr(OFS_BAUD, 32'h4);
		wr(OFS_SECONDARY, (32'h1 << B_RECEIVER_ENABLE_BIT) | (32'h1 << B_HW_SELECT_ENABLE));
		wr(OFS_PRIMARY, (32'(MODE_MASTER) << B_MODE) | (32'h1 << B_ENABLE));
		standby_i <= 1'b1;
		tick(4);
		wr(OFS_DATA, 32'hc3);
		tick(1);
		chk(32'(ss_n_o), 32'h0, "hw select in frame");
		chk(32'(core_clk_req_o), 32'h1, "clock kept in frame");
		tick(120);
		chk(32'(ss_n_o), 32'h1, "hw select released");
		chk(32'(core_clk_req_o), 32'h0, "clock stopped after frame");
		standby_i <= 1'b0;
		rd(OFS_DATA, d);
		chk(d & 32'hff, 32'hc3, "loop-back char");
	endtask
	task automatic t_soft_reset_bit();
		wr(OFS_PRIMARY, pctl(4'h0, 1'b0) | 32'h1);
		rdbit(OFS_STATUS, B_BUSY, 1'b1, "sync busy");
		tick(6);
		rd(OFS_PRIMARY, d);
		chk(d, RST_CTRL, "soft reset");
	endtask
	// ==========================================
	// Main sequence and hang guard
	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end
	initial begin
		arst_n_i = 1'b0;
		we_i = 1'b0;
		re_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		standby_i = 1'b0;
		repeat (12) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		@(posedge core_clk_i);
		t_regs();
		t_no_preload();
		t_preload();
		t_ovf_now();
		t_ovf_late();
		t_addr();
		t_irq();
		t_standby();
		t_master();
		t_soft_reset_bit();
		end_sim();
	end
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == LIMIT) begin
			num_errors++;
			$display("mismatch at %0t: run too long", $time);
			end_sim();
		end
	end
endmodule
